// ==== logic/axil_slave.sv ====
module axil_slave import line_regs_pkg::*; (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    reg_access_if.bus              rb
);
    typedef struct packed {
        logic             aw_got;
        logic             w_got;
        logic [IDX_W-1:0] w_idx;
        logic [7:0]       w_data;
        logic             w_lane;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [7:0]       rdata;
        logic [1:0]       rresp;
    } axil_state_s;
    axil_state_s st_reg;
    axil_state_s st_next;
    assign awready    = !st_reg.aw_got && !st_reg.bvalid;
    assign wready     = !st_reg.w_got && !st_reg.bvalid;
    assign arready    = !st_reg.rvalid;
    assign rb.wr_stb  = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    assign rb.wr_idx  = st_reg.w_idx;
    assign rb.wr_data = st_reg.w_data;
    assign rb.wr_lane = st_reg.w_lane;
    assign rb.rd_stb  = arvalid && !st_reg.rvalid;
    assign rb.rd_idx  = araddr[ADDR_W-1:2];
    always_comb begin
        st_next = st_reg;
        if (awvalid && awready) begin
            st_next.aw_got = 1'b1;
            st_next.w_idx  = awaddr[ADDR_W-1:2];
        end
        if (wvalid && wready) begin
            st_next.w_got  = 1'b1;
            st_next.w_data = wdata[7:0];
            st_next.w_lane = wstrb[0];
        end
        if (rb.wr_stb) begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = rb.wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (st_reg.bvalid && bready) begin
            st_next.bvalid = 1'b0;
        end
        if (rb.rd_stb) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rb.rd_data;
            st_next.rresp  = rb.rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (st_reg.rvalid && rready) begin
            st_next.rvalid = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign bvalid = st_reg.bvalid;
    assign bresp  = st_reg.bresp;
    assign rvalid = st_reg.rvalid;
    assign rresp  = st_reg.rresp;
    assign rdata  = {24'h000000, st_reg.rdata};
endmodule // axil_slave

// ==== logic/chan_status.sv ====
module chan_status import line_regs_pkg::*; (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  live,
    input  wire logic [3:0]  edge_any,
    input  wire logic        pattern_err,
    input  wire logic        err_event,
    input  wire logic        load,
    input  wire logic [5:0]  clr,
    output logic      [5:0]  flags,
    output logic      [15:0] shown
);
    typedef struct packed {
        logic [3:0]  live_prev;
        logic [5:0]  flags;
        logic [15:0] acc;
        logic [15:0] shown;
    } chan_state_s;
    chan_state_s st_reg;
    chan_state_s st_next;
    logic [5:0]  set;
    logic        ovf;
    always_comb begin
        st_next = st_reg;
        for (int i = 0; i < 4; i++) begin
            set[i+2] = edge_any[i] ? (live[i] ^ st_reg.live_prev[i])
                                   : (live[i] & ~st_reg.live_prev[i]);
        end
        ovf    = err_event && !load && (st_reg.acc == CNT_MAX);
        set[1] = pattern_err;
        set[0] = ovf;
        st_next.flags     = (st_reg.flags & ~clr) | set;
        st_next.live_prev = live;
        if (load) begin
            st_next.shown = st_reg.acc;
            st_next.acc   = {15'h0000, err_event};
        end else if (err_event && !ovf) begin
            st_next.acc = st_reg.acc + 16'h0001;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '{4'h0, STATUS_RESET, CNT_RESET, CNT_RESET};
        end else begin
            st_reg <= st_next;
        end
    end
    assign flags = st_reg.flags;
    assign shown = st_reg.shown;
endmodule // chan_status

// ==== logic/line_regs_pkg.sv ====
// Behaviour
// - Bit 5 latches system bipolar violation
// - Bit 4 latches line bipolar violation
// - Bit 3 latches system excess zeros
// - Bit 2 latches line excess zeros
// - Bit 1 latches pattern bit error
// - Bit 0 latches error counter overflow
// - Write one clears, zero keeps, reset zero
// - Status register read/write, 00H, 7-6 reserved
// - Interrupt output high while any flag set
// - Status at 022H step 40H, channel 0 7E2H
// - Counter 16 bits as low/high bytes
// - Counter bytes update auto or on request
// - Low byte read-only, 00H, channel 0 7E3H
// - Jitter config only at 7E5H, 7-3 reserved
// - Stop bit rise loads peaks, manual only
// - Mode bit 1: zero manual, one auto second
// - Edge select: rising only, or both edges
// - Peaks are 12 bits, value over 16 UI
package line_regs_pkg;
    localparam int          CLK_PERIOD_NS     = 8;
    localparam int          ONE_SECOND_NS     = 1_000_000_000;
    localparam int          ONE_SECOND_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;
    localparam int          NUM_CH            = 17;
    localparam int          ADDR_W            = 13;
    localparam int          IDX_W             = 11;
    localparam int          TIMER_W           = 27;
    localparam logic [5:0]  OFS_STATUS        = 6'h22;
    localparam logic [5:0]  OFS_CNT_LOW       = 6'h23;
    localparam logic [5:0]  OFS_CNT_HIGH      = 6'h24;
    localparam logic [4:0]  CH0_BANK          = 5'h1F;
    localparam logic [10:0] IDX_STATUS_CH1    = 11'h022;
    localparam logic [10:0] IDX_CH_STEP       = 11'h040;
    localparam logic [10:0] IDX_STATUS_CH0    = 11'h7E2;
    localparam logic [10:0] IDX_CNT_LOW_CH0   = 11'h7E3;
    localparam logic [10:0] IDX_JM            = 11'h7E5;
    localparam logic [10:0] IDX_POS_LOW       = 11'h7E6;
    localparam logic [10:0] IDX_POS_HIGH      = 11'h7E7;
    localparam logic [10:0] IDX_NEG_LOW       = 11'h7E8;
    localparam logic [10:0] IDX_NEG_HIGH      = 11'h7E9;
    localparam logic [10:0] IDX_EDGE_SEL      = 11'h7F0;
    localparam logic [10:0] IDX_ERR_CFG       = 11'h7F1;
    localparam int          JITTER_MANUAL_STOP_BIT       = 2;
    localparam int          JM_MODE_BIT       = 1;
    localparam int          JM_BAND_BIT       = 0;
    localparam int          CNT_MODE_BIT      = 1;
    localparam int          CNT_UPDATE_BIT    = 0;
    localparam logic [5:0]  STATUS_RESET      = 6'h00;
    localparam logic [15:0] CNT_RESET         = 16'h0000;
    localparam logic [15:0] CNT_MAX           = 16'hFFFF;
    localparam logic [11:0] PEAK_RESET        = 12'h000;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage

// ==== logic/line_status_regs.sv ====
module line_status_regs import line_regs_pkg::*; #(
    parameter int SECOND_CYCLES = ONE_SECOND_CYCLES
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [NUM_CH-1:0] sys_bipolar_violation,
    input  wire logic [NUM_CH-1:0] line_bipolar_violation,
    input  wire logic [NUM_CH-1:0] sys_excess_zeros,
    input  wire logic [NUM_CH-1:0] line_excess_zeros,
    input  wire logic [NUM_CH-1:0] pattern_error_event,
    input  wire logic [NUM_CH-1:0] error_count_event,
    input  wire logic [11:0]       pos_peak_value,
    input  wire logic [11:0]       neg_peak_value,
    output logic                   irq,
    output logic                   jitter_band_select,
    output logic                   jitter_period_mode
);
    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef struct packed {
        logic       hit;
        logic [4:0] ch;
    } chan_sel_s;

    typedef struct packed {
        logic [3:0]         edge_sel;
        logic               cnt_manual;
        logic               jitter_manual_stop;
        logic               jm_mode;
        logic               jm_band;
        logic [11:0]        pos_peak;
        logic [11:0]        neg_peak;
        logic [TIMER_W-1:0] timer;
    } top_state_s;

    top_state_s st_reg;
    top_state_s st_next;

    reg_access_if rb ();

    logic [5:0]  ch_flags [NUM_CH];
    logic [15:0] ch_shown [NUM_CH];
    logic [5:0]  ch_clr   [NUM_CH];
    logic        tick;
    logic        cnt_load;
    logic        jm_load;
    logic        jm_wr;
    logic        cfg_wr;
    logic        stat_wr;
    logic [7:0]  rd_data_c;
    logic        rd_ok_c;
    logic        wr_ok_c;
    logic [NUM_CH-1:0] any_flag;
    chan_sel_s   rdec;
    chan_sel_s   wdec;

    // ------------------------------------------------------------
    // Channel address decode
    // ------------------------------------------------------------
    function automatic chan_sel_s chan_decode(input logic [IDX_W-1:0] idx);
        chan_sel_s r;
        logic      ofs_ok;
        ofs_ok = (idx[5:0] == OFS_STATUS) || (idx[5:0] == OFS_CNT_LOW)
              || (idx[5:0] == OFS_CNT_HIGH);
        r.hit  = ofs_ok && (!idx[10] || (idx[10:6] == CH0_BANK));
        r.ch   = idx[10] ? 5'h00 : ({1'b0, idx[9:6]} + 5'h01);
        return r;
    endfunction

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    axil_slave u_axil (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .rb      (rb.bus)
    );

    assign rb.rd_data = rd_data_c;
    assign rb.rd_ok   = rd_ok_c;
    assign rb.wr_ok   = wr_ok_c;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        chan_status u_chan (
            .aclk        (aclk),
            .aresetn     (aresetn),
            .live        ({sys_bipolar_violation[c], line_bipolar_violation[c],
                           sys_excess_zeros[c], line_excess_zeros[c]}),
            .edge_any    (st_reg.edge_sel),
            .pattern_err (pattern_error_event[c]),
            .err_event   (error_count_event[c]),
            .load        (cnt_load),
            .clr         (ch_clr[c]),
            .flags       (ch_flags[c]),
            .shown       (ch_shown[c])
        );
        assign any_flag[c] = |ch_flags[c];
    end

    assign irq = |any_flag;
    assign jitter_band_select = st_reg.jm_band;
    assign jitter_period_mode = st_reg.jm_mode;

    // ------------------------------------------------------------
    // Next state, writes and read mux
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        wdec    = chan_decode(rb.wr_idx);
        rdec    = chan_decode(rb.rd_idx);
        tick    = (st_reg.timer == TIMER_W'(SECOND_CYCLES - 1));
        jm_wr   = rb.wr_stb && rb.wr_lane && (rb.wr_idx == IDX_JM);
        cfg_wr  = rb.wr_stb && rb.wr_lane && (rb.wr_idx == IDX_ERR_CFG);
        stat_wr = rb.wr_stb && rb.wr_lane && wdec.hit && (rb.wr_idx[5:0] == OFS_STATUS);
        wr_ok_c = wdec.hit || (rb.wr_idx >= IDX_JM && rb.wr_idx <= IDX_NEG_HIGH)
               || (rb.wr_idx == IDX_EDGE_SEL) || (rb.wr_idx == IDX_ERR_CFG);
        st_next.timer = tick ? '0 : st_reg.timer + TIMER_W'(1);

        for (int c = 0; c < NUM_CH; c++) begin
            ch_clr[c] = (stat_wr && (wdec.ch == 5'(c))) ? rb.wr_data[5:0] : 6'h00;
        end

        cnt_load = st_reg.cnt_manual ? (cfg_wr && rb.wr_data[CNT_UPDATE_BIT])
                                     : tick;
        jm_load  = st_reg.jm_mode ? tick
                 : (jm_wr && rb.wr_data[JITTER_MANUAL_STOP_BIT] && !st_reg.jitter_manual_stop);

        if (jm_load) begin
            st_next.pos_peak = pos_peak_value;
            st_next.neg_peak = neg_peak_value;
        end
        if (jm_wr) begin
            st_next.jitter_manual_stop = rb.wr_data[JITTER_MANUAL_STOP_BIT];
            st_next.jm_mode = rb.wr_data[JM_MODE_BIT];
            st_next.jm_band = rb.wr_data[JM_BAND_BIT];
        end
        if (cfg_wr) begin
            st_next.cnt_manual = rb.wr_data[CNT_MODE_BIT];
        end
        if (rb.wr_stb && rb.wr_lane && rb.wr_idx == IDX_EDGE_SEL) begin
            st_next.edge_sel = rb.wr_data[3:0];
        end

        rd_data_c = 8'h00;
        rd_ok_c   = 1'b1;
        if (rdec.hit) begin
            case (rb.rd_idx[5:0])
                OFS_STATUS:   rd_data_c = {2'b00, ch_flags[rdec.ch]};
                OFS_CNT_LOW:  rd_data_c = ch_shown[rdec.ch][7:0];
                default:      rd_data_c = ch_shown[rdec.ch][15:8];
            endcase
        end else begin
            case (rb.rd_idx)
                IDX_JM:       rd_data_c = {5'h00, st_reg.jitter_manual_stop, st_reg.jm_mode,
                                           st_reg.jm_band};
                IDX_POS_LOW:  rd_data_c = st_reg.pos_peak[7:0];
                IDX_POS_HIGH: rd_data_c = {4'h0, st_reg.pos_peak[11:8]};
                IDX_NEG_LOW:  rd_data_c = st_reg.neg_peak[7:0];
                IDX_NEG_HIGH: rd_data_c = {4'h0, st_reg.neg_peak[11:8]};
                IDX_EDGE_SEL: rd_data_c = {4'h0, st_reg.edge_sel};
                IDX_ERR_CFG:  rd_data_c = {6'h00, st_reg.cnt_manual, 1'b0};
                default:      rd_ok_c = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '{4'h0, 1'b0, 1'b0, 1'b0, 1'b0, PEAK_RESET, PEAK_RESET, '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_SYS_BPV_RISE: assert property (
        $rose(sys_bipolar_violation[0]) |=> ch_flags[0][5] && irq)
        else $error("system bipolar violation not latched");

    AST_LINE_BPV_BOTH: assert property (
        st_reg.edge_sel[2] && $fell(line_bipolar_violation[1]) |=> ch_flags[1][4])
        else $error("line bipolar fall not latched with edge select");

    AST_SYS_EXZ_RISE: assert property (
        $rose(sys_excess_zeros[2]) |=> ch_flags[2][3])
        else $error("system excess zeros not latched");

    AST_LINE_EXZ_FALL_ONLY: assert property (
        !st_reg.edge_sel[0] && $fell(line_excess_zeros[3]) && !ch_flags[3][2]
        && !$rose(line_excess_zeros[3]) |=> !ch_flags[3][2])
        else $error("falling edge set flag in rising mode");

    AST_PATTERN_ERR: assert property (
        pattern_error_event[4] |=> ch_flags[4][1] ##0 irq)
        else $error("pattern error not latched");

    AST_OVF_CAUSE: assert property (
        $rose(ch_flags[0][0]) |-> $past(error_count_event[0]))
        else $error("overflow flag without count event");

    AST_W1C: assert property (
        rb.wr_stb && rb.wr_lane && rb.wr_idx == IDX_STATUS_CH0
        && rb.wr_data[1] && !pattern_error_event[0] |=> !ch_flags[0][1])
        else $error("write one did not clear flag");

    AST_IRQ_HOLD: assert property (
        any_flag[16] |-> irq)
        else $error("interrupt low with flag set");

    AST_STATUS_MAP: assert property (
        rb.rd_stb && rb.rd_idx == IDX_STATUS_CH1 + IDX_CH_STEP
        |-> rb.rd_data == {2'b00, ch_flags[2]})
        else $error("channel two status decode wrong");

    AST_CNT_LOW_MAP: assert property (
        rb.rd_stb && rb.rd_idx == IDX_CNT_LOW_CH0 |-> rb.rd_data == ch_shown[0][7:0])
        else $error("channel zero low byte decode wrong");

    AST_CNT_HOLD: assert property (
        !cnt_load |=> $stable(ch_shown[5]))
        else $error("counter bytes changed without update");

    AST_JITTER_MANUAL_STOP_LOAD: assert property (
        jm_wr && rb.wr_data[JITTER_MANUAL_STOP_BIT] && !st_reg.jitter_manual_stop && !st_reg.jm_mode
        |=> st_reg.pos_peak == $past(pos_peak_value) && st_reg.neg_peak == $past(neg_peak_value))
        else $error("stop rise did not load peaks");

    AST_JM_AUTO_HOLD: assert property (
        st_reg.jm_mode && !tick |=> $stable(st_reg.pos_peak))
        else $error("peaks changed inside auto period");

    AST_JM_RESERVED: assert property (
        rb.rd_stb && rb.rd_idx == IDX_JM |-> rb.rd_data[7:3] == 5'h00)
        else $error("jitter config reserved bits not zero");

    COVER_STATUS_CLEAR: cover property (
        ch_flags[0] != 6'h00 ##[1:20] ch_flags[0] == 6'h00);
    COVER_MANUAL_STOP: cover property (jm_load && !st_reg.jm_mode);
    COVER_MANUAL_COUNT: cover property (cnt_load && st_reg.cnt_manual);
    COVER_SLVERR: cover property (rb.rd_stb && !rb.rd_ok);
endmodule // line_status_regs

// ==== logic/reg_access_if.sv ====
interface reg_access_if;
    import line_regs_pkg::*;
    logic             wr_stb;
    logic [IDX_W-1:0] wr_idx;
    logic [7:0]       wr_data;
    logic             wr_lane;
    logic             wr_ok;
    logic             rd_stb;
    logic [IDX_W-1:0] rd_idx;
    logic [7:0]       rd_data;
    logic             rd_ok;
    modport bus  (output wr_stb, wr_idx, wr_data, wr_lane, rd_stb, rd_idx, input wr_ok, rd_data, rd_ok);
    modport regs (input wr_stb, wr_idx, wr_data, wr_lane, rd_stb, rd_idx, output wr_ok, rd_data, rd_ok);
endinterface

// ==== test/line_status_regs_tb.sv ====
module line_status_regs_tb import line_regs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------
    // Bench signals
    // ----------------
    logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic              awready, wready, bvalid, arready, rvalid, irq, band, pmode;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata, rd_v, lf;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, rs;
    logic [NUM_CH-1:0] sbv, lbv, sez, lez, pev, cev;
    logic [11:0]       ppk, npk, pold;
    int                miscompares, checks, n;
    int                st_m [NUM_CH];

    line_status_regs #(.SECOND_CYCLES(50)) i_line_status_regs (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sys_bipolar_violation(sbv), .line_bipolar_violation(lbv), .sys_excess_zeros(sez),
        .line_excess_zeros(lez), .pattern_error_event(pev), .error_count_event(cev),
        .pos_peak_value(ppk), .neg_peak_value(npk), .irq(irq), .jitter_band_select(band),
        .jitter_period_mode(pmode));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [10:0] idx(input int ch, input int off);
        return (ch == 0) ? IDX_STATUS_CH0 + 11'(off) : IDX_STATUS_CH1 + 11'(IDX_CH_STEP * (ch - 1) + off);
    endfunction

    task automatic results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [10:0] i, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        logic aw, w, b;
        awaddr <= {i, 2'b00};
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int k = 0; k < 200; k++) begin
            @(negedge aclk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) begin
                chk("bresp", 32'(rs), 32'(er));
                return;
            end
        end
        miscompares++;
        results;
    endtask

    task automatic rc(input string nm, input logic [10:0] i, input logic [31:0] e, input logic [1:0] er);
        logic ar, r;
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        for (int k = 0; k < 200; k++) begin
            @(negedge aclk);
            ar = arvalid && arready;
            r = rvalid;
            rd_v = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ar) arvalid <= 1'b0;
            if (r) begin
                chk(nm, rd_v, e);
                chk("rresp", 32'(rs), 32'(er));
                return;
            end
        end
        miscompares++;
        results;
    endtask

    task automatic pulse(input int k, input int ch);
        logic [NUM_CH-1:0] v;
        v = NUM_CH'(1) << ch;
        case (k)
            0: sbv <= v;
            1: lbv <= v;
            2: sez <= v;
            3: lez <= v;
            default: pev <= v;
        endcase
        @(posedge aclk);
        {sbv, lbv, sez, lez, pev} <= '0;
        @(posedge aclk);
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, wstrb} = '0;
        {awaddr, araddr, wdata, sbv, lbv, sez, lez, pev, cev, ppk, npk} = '0;
        miscompares = 0;
        checks = 0;
        lf = 32'h07FA;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        {bready, rready} <= 2'b11;
        @(posedge aclk);
        for (int c = 0; c < NUM_CH; c++) begin
            st_m[c] = 0;
            for (int o = 0; o < 3; o++) rc("reset", idx(c, o), 0, RESP_OKAY);
        end
        rc("jm reset", IDX_JM, 0, RESP_OKAY);
        for (int c = 0; c < NUM_CH; c++) begin
            for (int k = 0; k < 5; k++) begin
                pulse(k, c);
                st_m[c] |= 1 << (5 - k);
            end
            rc("flags", idx(c, 0), st_m[c], RESP_OKAY);
            chk("irq set", irq, 1);
            lf = lfsr(lf);
            wr(idx(c, 0), lf[7:0]);
            st_m[c] &= ~int'(lf[7:0]);
            rc("w1c", idx(c, 0), st_m[c], RESP_OKAY);
            wr(idx(c, 0), 8'hFF);
            rc("cleared", idx(c, 0), 0, RESP_OKAY);
            chk("irq clr", irq, 0);
        end
        wr(IDX_EDGE_SEL, 8'h0C);
        {sbv[3], lbv[1], lez[3]} <= 3'b111;
        repeat (2) @(posedge aclk);
        wr(idx(3, 0), 8'hFF);
        wr(idx(1, 0), 8'hFF);
        {sbv, lbv, lez} <= '0;
        repeat (2) @(posedge aclk);
        rc("fall edge", idx(3, 0), 32'h20, RESP_OKAY);
        rc("fall both", idx(1, 0), 32'h10, RESP_OKAY);
        wr(idx(3, 0), 8'hFF);
        wr(idx(1, 0), 8'hFF);
        wr(IDX_EDGE_SEL, 8'h00);
        wr(IDX_ERR_CFG, 8'h02);
        lf = lfsr(lf);
        n = 1 + int'(lf[3:0]);
        cev[5] <= 1'b1;
        repeat (n) @(posedge aclk);
        cev <= '0;
        @(posedge aclk);
        wr(IDX_ERR_CFG, 8'h03);
        rc("cnt low", idx(5, 1), n, RESP_OKAY);
        rc("cnt high", idx(5, 2), 0, RESP_OKAY);
        wr(idx(5, 1), 8'h55);
        rc("cnt ro", idx(5, 1), n, RESP_OKAY);
        cev[0] <= 1'b1;
        repeat (65536) @(posedge aclk);
        cev <= '0;
        @(posedge aclk);
        wr(IDX_ERR_CFG, 8'h03);
        rc("ovf low", IDX_CNT_LOW_CH0, 32'hFF, RESP_OKAY);
        rc("ovf high", IDX_CNT_LOW_CH0 + 11'h001, 32'hFF, RESP_OKAY);
        rc("ovf flag", IDX_STATUS_CH0, 32'h01, RESP_OKAY);
        wr(IDX_STATUS_CH0, 8'h01);
        lf = lfsr(lf);
        ppk <= lf[11:0];
        npk <= lf[23:12];
        wr(IDX_JM, 8'hF9);
        chk("band", band, 1);
        rc("jm rsvd", IDX_JM, 32'h01, RESP_OKAY);
        wr(IDX_JM, 8'h05);
        pold = lf[11:0];
        rc("pos lo", IDX_POS_LOW, pold[7:0], RESP_OKAY);
        rc("pos hi", IDX_POS_HIGH, pold[11:8], RESP_OKAY);
        rc("neg lo", IDX_NEG_LOW, lf[19:12], RESP_OKAY);
        rc("neg hi", IDX_NEG_HIGH, lf[23:20], RESP_OKAY);
        ppk <= ~pold;
        wr(IDX_JM, 8'h01);
        rc("no load", IDX_POS_LOW, pold[7:0], RESP_OKAY);
        wr(IDX_JM, 8'h03);
        chk("mode", pmode, 1);
        repeat (60) @(posedge aclk);
        rc("auto", IDX_POS_LOW, {24'h000000, ~pold[7:0]}, RESP_OKAY);
        rc("unmapped", 11'h7FF, 0, RESP_SLVERR);
        wr(11'h7FF, 8'h00, RESP_SLVERR);
        results;
    end
endmodule // line_status_regs_tb
